// ### verilog/ubam_pkg.sv
// package for the uart baud generator and auxiliary modes
// assumes an apb master on mclk and a remote station on the serial pins
package ubam_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00; // uart_ctrl_status_reg
  localparam logic [7:0] OFF_RXC   = 8'h04; // uart_rx_ctrl_reg
  localparam logic [7:0] OFF_INTC  = 8'h08; // uart_int_ctrl_reg
  localparam logic [7:0] OFF_PSR   = 8'h0c; // prescaler_select_reg
  localparam logic [7:0] OFF_BAUD  = 8'h10; // low divisor byte
  localparam logic [7:0] OFF_TXBUF = 8'h14; // tx_holding_buffer
  localparam logic [7:0] OFF_RXBUF = 8'h18; // rx_holding_buffer
  localparam logic [7:0] OFF_PWR   = 8'h1c; // halt/idle and wake control
  localparam logic [7:0] OFF_BITOP = 8'h20; // bit access to rx ctrl
  // ctrl bits
  localparam int CTL_TX_NINTH_BIT = 0;
  localparam int CTL_CHAR_LENGTH_SEL_LO  = 1;
  localparam int CTL_CHAR_LENGTH_SEL_HI  = 2;
  localparam int CTL_TX_BUFFER_EMPTY_FLAG  = 3;
  localparam int CTL_RX_BUFFER_FULL_FLAG  = 4;
  // rx ctrl bits
  localparam int RXC_ADDRESS_HUNT_BIT  = 0;
  localparam int RXC_RX_NINTH_BIT = 1;
  localparam int RXC_FERR  = 2;
  localparam int RXC_OERR  = 3;
  // int ctrl bits
  localparam int INT_SSEL  = 0;
  localparam int INT_BRK   = 1;
  localparam int INT_ERI   = 2;
  // power reg bits
  localparam int PWR_HALT  = 0;
  localparam int PWR_IDLE  = 1;
  localparam int PWR_XTAL  = 2;
  localparam int PWR_WAKE_ENABLE_REG  = 3; // wake_enable_reg bit 3
  localparam int PWR_WAKE_EDGE_REG = 4; // wake_edge_reg bit 4
  localparam int PWR_SLEEP = 5; // read-only asleep status
  localparam int PWR_HOLD  = 6; // read-only wake delay running
  // widths
  localparam int DIV_W  = 11;
  localparam int PS_W   = 5;
  localparam int CHAR_W = 9;
  localparam int FRAME_W = 11;
  // timing
  localparam int MCLK_MHZ     = 250;
  localparam int TC_NS        = 1000; // instruction cycle time, 1 us
  localparam int WAKE_TC      = 256;
  localparam int TC_CYC       = TC_NS * MCLK_MHZ / 1000;
  localparam int WAKE_CYC     = WAKE_TC * TC_CYC;
  localparam logic [4:0] OVS_ASYNC = 5'h10;
  localparam logic [4:0] OVS_SYNC  = 5'h02;
  localparam logic [8:0] TX_SHIFT_REGISTER_ONES = 9'h1ff;
  // rx states
  typedef enum logic [2:0] {
    UBAM_RX_IDLE  = 3'b001,
    UBAM_RX_START = 3'b010,
    UBAM_RX_DATA  = 3'b100
  } ubam_rx_st_t;
  // apb request bundle
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } ubam_req_t;
endpackage

// ### verilog/ubam_top.sv
// baud generator, halt/idle handling, wake, loopback, address hunt, break
// assumes apb master on mclk; serial_in_pin is asynchronous
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module ubam_top #(
  parameter int WAKE_CYCLES = ubam_pkg::WAKE_CYC
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             baud_tick,
  output logic             rx_int,
  output logic             core_run
);
  // registers
  logic [8:0]  ctrl_r;      // tx_ninth_bit, char_length_sel_lo, char_length_sel_hi (rw)
  logic        tx_buffer_empty_flag_r;
  logic        rx_buffer_full_flag_r;
  logic        address_hunt_bit_r;
  logic        rx_ninth_bit_r;
  logic        ferr_r;
  logic [2:0]  intc_r;
  logic [7:0]  psr_r;       // [7:3] code, [2:0] divisor high
  logic [7:0]  baud_r;
  logic [7:0]  txbuf_r;
  logic [7:0]  rxbuf_r;
  logic [4:0]  pwr_r;
  logic        asleep_r;
  logic        hold_r;
  logic [31:0] wake_cnt_r;
  logic [8:0]  tx_shift_register_r;
  logic [8:0]  rx_shift_register_r;
  logic [31:0] prdata_r;
  ubam_pkg::ubam_req_t req;

  assign req = '{wr: pwrite, addr: paddr, wdata: pwdata};
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = prdata_r;

  wire acc  = psel & penable;
  wire wr   = acc & req.wr;
  wire rd   = acc & ~req.wr;
  wire loop = ctrl_r[ubam_pkg::CTL_CHAR_LENGTH_SEL_LO] & ctrl_r[ubam_pkg::CTL_CHAR_LENGTH_SEL_HI];
  wire ssel = intc_r[ubam_pkg::INT_SSEL];

  // input synchroniser
  logic rx_m_r, rx_s_r;
  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
    end else begin
      rx_m_r <= serial_in_pin;
      rx_s_r <= rx_m_r;
    end
  end

  // halt/idle entry pulse
  wire sleep_req = wr && req.addr == ubam_pkg::OFF_PWR &&
                   (req.wdata[ubam_pkg::PWR_HALT] |
                    req.wdata[ubam_pkg::PWR_IDLE]);
  wire reinit = sleep_req & ~asleep_r;

  // prescaler: half steps via counting doubled mclk
  logic [5:0] ps_acc_r;
  logic       ps_tick;
  wire [4:0]  ps_code = psr_r[7:3];
  wire [5:0]  ps_lim  = {1'b0, ps_code} + 6'h01; // 2*P
  always_ff @(posedge mclk) begin
    if (srst || ps_code == 5'h00) begin
      ps_acc_r <= 6'h00;
    end else if (ps_acc_r + 6'h02 >= ps_lim) begin
      ps_acc_r <= 6'(ps_acc_r + 6'h02 - ps_lim);
    end else begin
      ps_acc_r <= 6'(ps_acc_r + 6'h02);
    end
  end
  assign ps_tick = ps_code != 5'h00 && (ps_acc_r + 6'h02 >= ps_lim);

  // 11-bit divisor counter
  logic [10:0] div_cnt_r;
  wire  [10:0] div_val = {psr_r[2:0], baud_r};
  logic        ovs_tick;
  always_ff @(posedge mclk) begin
    if (srst) begin
      div_cnt_r <= 11'h000;
    end else if (ps_tick) begin
      div_cnt_r <= (div_cnt_r == 11'h000) ? div_val :
                   11'(div_cnt_r - 11'h001);
    end
  end
  assign ovs_tick = ps_tick && div_cnt_r == 11'h000;

  // divide by 16 async or 2 sync
  logic [4:0] ovs_cnt_r;
  wire  [4:0] ovs_lim = ssel ? ubam_pkg::OVS_SYNC : ubam_pkg::OVS_ASYNC;
  always_ff @(posedge mclk) begin
    if (srst) begin
      ovs_cnt_r <= 5'h00;
    end else if (ovs_tick) begin
      ovs_cnt_r <= (ovs_cnt_r >= ovs_lim - 5'h01) ? 5'h00 :
                   5'(ovs_cnt_r + 5'h01);
    end
  end
  assign baud_tick = ovs_tick && ovs_cnt_r >= ovs_lim - 5'h01;

  // transmitter: nine data bits with ninth from tx_ninth_bit
  logic [3:0] tx_bit_r;
  logic       tx_busy_r;
  logic       tx_line_r;
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_shift_register_r    <= ubam_pkg::TX_SHIFT_REGISTER_ONES;
      tx_bit_r  <= 4'h0;
      tx_busy_r <= 1'b0;
      tx_line_r <= 1'b1;
    end else if (reinit) begin
      tx_shift_register_r    <= ubam_pkg::TX_SHIFT_REGISTER_ONES;
      tx_busy_r <= 1'b0;
      tx_line_r <= 1'b1;
    end else if (baud_tick) begin
      if (!tx_busy_r && !tx_buffer_empty_flag_r) begin
        tx_shift_register_r    <= {ctrl_r[ubam_pkg::CTL_TX_NINTH_BIT], txbuf_r};
        tx_line_r <= 1'b0;
        tx_bit_r  <= 4'h0;
        tx_busy_r <= 1'b1;
      end else if (tx_busy_r) begin
        tx_line_r <= (tx_bit_r < 4'h9) ? tx_shift_register_r[0] : 1'b1;
        tx_shift_register_r    <= {1'b1, tx_shift_register_r[8:1]};
        tx_bit_r  <= 4'(tx_bit_r + 4'h1);
        if (tx_bit_r == 4'h9) begin
          tx_busy_r <= 1'b0;
        end
      end
    end
  end
  // break forces line low
  assign serial_out_pin = intc_r[ubam_pkg::INT_BRK] ? 1'b0 :
                          tx_line_r;

  // receiver: loopback takes tx line
  wire rx_line = loop ? tx_line_r : rx_s_r;
  ubam_pkg::ubam_rx_st_t rx_st_r;
  logic [3:0] rx_bit_r;
  logic       rx_done;
  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_st_r  <= ubam_pkg::UBAM_RX_IDLE;
      rx_bit_r <= 4'h0;
      rx_shift_register_r   <= 9'h000;
    end else if (baud_tick) begin
      unique case (rx_st_r)
        ubam_pkg::UBAM_RX_IDLE: begin
          if (!rx_line) rx_st_r <= ubam_pkg::UBAM_RX_DATA;
          rx_bit_r <= 4'h0;
        end
        ubam_pkg::UBAM_RX_START: rx_st_r <= ubam_pkg::UBAM_RX_DATA;
        ubam_pkg::UBAM_RX_DATA: begin
          if (rx_bit_r < 4'h9) begin
            rx_shift_register_r <= {rx_line, rx_shift_register_r[8:1]};
          end
          rx_bit_r <= 4'(rx_bit_r + 4'h1);
          if (rx_bit_r == 4'h9) rx_st_r <= ubam_pkg::UBAM_RX_IDLE;
        end
      endcase
    end
  end
  assign rx_done = baud_tick && rx_st_r == ubam_pkg::UBAM_RX_DATA &&
                   rx_bit_r == 4'h9;
  wire stop_ok = rx_line;
  // character accepted unless hunting and ninth bit zero
  wire accept  = rx_done && (!address_hunt_bit_r || rx_shift_register_r[8]);

  // rw control registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_r  <= 9'h000;
      intc_r  <= 3'h0;
      psr_r   <= 8'h00;
      baud_r  <= 8'h00;
      txbuf_r <= 8'h00;
      pwr_r   <= 5'h00;
    end else if (wr) begin
      unique case (req.addr)
        ubam_pkg::OFF_CTRL:  ctrl_r  <= {6'h00, req.wdata[2:0]};
        ubam_pkg::OFF_INTC:  intc_r  <= req.wdata[2:0];
        ubam_pkg::OFF_PSR:   psr_r   <= req.wdata[7:0];
        ubam_pkg::OFF_BAUD:  baud_r  <= req.wdata[7:0];
        ubam_pkg::OFF_TXBUF: txbuf_r <= req.wdata[7:0];
        ubam_pkg::OFF_PWR:   pwr_r   <= req.wdata[4:0];
        default: ;
      endcase
    end
  end

  // status flags; hardware set wins over clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_buffer_empty_flag_r <= 1'b1;
      rx_buffer_full_flag_r <= 1'b0;
      rx_ninth_bit_r <= 1'b0;
      ferr_r <= 1'b0;
      rxbuf_r <= 8'h00;
    end else if (reinit) begin
      tx_buffer_empty_flag_r  <= 1'b1;
      rx_buffer_full_flag_r  <= 1'b0;
      rx_ninth_bit_r <= 1'b0;
      ferr_r  <= 1'b0;
    end else begin
      if (baud_tick && !tx_busy_r && !tx_buffer_empty_flag_r) tx_buffer_empty_flag_r <= 1'b1;
      else if (wr && req.addr == ubam_pkg::OFF_TXBUF) tx_buffer_empty_flag_r <= 1'b0;
      if (accept) begin
        rx_buffer_full_flag_r  <= 1'b1;
        rxbuf_r <= rx_shift_register_r[7:0];
        rx_ninth_bit_r <= rx_shift_register_r[8];
      end else if (rd && req.addr == ubam_pkg::OFF_RXBUF) begin
        rx_buffer_full_flag_r <= 1'b0;
      end
      if (rx_done && !stop_ok) ferr_r <= 1'b1;
      else if (acc && req.addr == ubam_pkg::OFF_BITOP) ferr_r <= 1'b0;
    end
  end

  // address hunt bit
  always_ff @(posedge mclk) begin
    if (srst) begin
      address_hunt_bit_r <= 1'b0;
    end else if (accept && address_hunt_bit_r) begin
      address_hunt_bit_r <= 1'b0;
    end else if (wr && req.addr == ubam_pkg::OFF_RXC) begin
      address_hunt_bit_r <= req.wdata[ubam_pkg::RXC_ADDRESS_HUNT_BIT];
    end
  end
  assign rx_int = rx_buffer_full_flag_r & intc_r[ubam_pkg::INT_ERI];

  // sleep, wake on falling serial input, crystal hold-off
  logic rx_prev_r;
  wire  wake_armed = pwr_r[ubam_pkg::PWR_WAKE_ENABLE_REG] & pwr_r[ubam_pkg::PWR_WAKE_EDGE_REG];
  wire  start_edge = rx_prev_r & ~rx_s_r;
  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_prev_r  <= 1'b1;
      asleep_r   <= 1'b0;
      hold_r     <= 1'b0;
      wake_cnt_r <= 32'h0;
    end else begin
      rx_prev_r <= rx_s_r;
      if (reinit) begin
        asleep_r <= 1'b1;
      end else if (asleep_r && wake_armed && start_edge) begin
        asleep_r <= 1'b0;
        hold_r   <= pwr_r[ubam_pkg::PWR_HALT] & pwr_r[ubam_pkg::PWR_XTAL];
        wake_cnt_r <= 32'(WAKE_CYCLES - 1);
      end else if (hold_r) begin
        if (wake_cnt_r == 32'h0) hold_r <= 1'b0;
        else wake_cnt_r <= 32'(wake_cnt_r - 32'h1);
      end
    end
  end
  assign core_run = ~asleep_r & ~hold_r;

  // read mux
  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata_r <= 32'h0;
    end else if (psel && !penable && !req.wr) begin
      unique case (req.addr)
        ubam_pkg::OFF_CTRL: prdata_r <= {27'h0, rx_buffer_full_flag_r, tx_buffer_empty_flag_r,
                                         ctrl_r[2:0]};
        ubam_pkg::OFF_RXC:  prdata_r <= {28'h0, 1'b0, ferr_r, rx_ninth_bit_r,
                                         address_hunt_bit_r};
        ubam_pkg::OFF_INTC:  prdata_r <= {29'h0, intc_r};
        ubam_pkg::OFF_PSR:   prdata_r <= {24'h0, psr_r};
        ubam_pkg::OFF_BAUD:  prdata_r <= {24'h0, baud_r};
        ubam_pkg::OFF_TXBUF: prdata_r <= {24'h0, txbuf_r};
        ubam_pkg::OFF_RXBUF: prdata_r <= {24'h0, rxbuf_r};
        ubam_pkg::OFF_PWR:   prdata_r <= {25'h0, hold_r, asleep_r, pwr_r};
        default:             prdata_r <= 32'h0;
      endcase
    end
  end

  // assertions
  a_break_low: assert property (@(posedge mclk) disable iff (srst)
    intc_r[ubam_pkg::INT_BRK] |-> !serial_out_pin)
    else $error("break not holding line low");
  a_code_zero: assert property (@(posedge mclk) disable iff (srst)
    psr_r[7:3] == 5'h00 |-> !baud_tick)
    else $error("baud tick with prescaler off");
  a_reinit_flags: assert property (@(posedge mclk) disable iff (srst)
    reinit |=> tx_buffer_empty_flag_r && !rx_buffer_full_flag_r && tx_shift_register_r == ubam_pkg::TX_SHIFT_REGISTER_ONES)
    else $error("halt entry did not reinit");
  a_reinit_buf: assert property (@(posedge mclk) disable iff (srst)
    reinit |=> $stable(rxbuf_r) && $stable(txbuf_r))
    else $error("halt entry changed buffers");
  a_hunt_clear: assert property (@(posedge mclk) disable iff (srst)
    accept && address_hunt_bit_r |=> !address_hunt_bit_r && rx_buffer_full_flag_r)
    else $error("hunt bit not cleared on address");
  a_hunt_drop: assert property (@(posedge mclk) disable iff (srst)
    rx_done && address_hunt_bit_r && !rx_shift_register_r[8] && !rx_buffer_full_flag_r |=> !rx_buffer_full_flag_r)
    else $error("data kept during hunt");
  a_div_reload: assert property (@(posedge mclk) disable iff (srst)
    ps_tick && div_cnt_r == 11'h000 |=> div_cnt_r == $past(div_val))
    else $error("divisor did not reload");
  a_loop_path: assert property (@(posedge mclk) disable iff (srst)
    loop |-> rx_line == tx_line_r)
    else $error("loopback path broken");
  a_bitop_err: assert property (@(posedge mclk) disable iff (srst)
    acc && paddr == ubam_pkg::OFF_BITOP && !rx_done |=> !ferr_r)
    else $error("bit access left error flag");
  c_wake: cover property (@(posedge mclk) asleep_r ##1 !asleep_r);
  c_addr: cover property (@(posedge mclk) accept && address_hunt_bit_r);
  c_loop: cover property (@(posedge mclk) loop && rx_done);
endmodule // ubam_top

// ### verif/ubam_station.sv
// remote serial station model driving the device's serial input
// assumes frames timed in whole mclk cycles per bit
`timescale 1ns/100ps
module ubam_station #(
  parameter int BIT_CYC = 16
) (
  input  wire logic mclk,
  output logic      line
);
  // line idles high between frames
  initial line = 1'b1;
  // one frame: start, nine data bits lsb first, stop
  task automatic send(input logic [8:0] d, input logic stp);
    line <= 1'b0;
    repeat (BIT_CYC) @(posedge mclk);
    for (int i = 0; i < 9; i++) begin
      line <= d[i];
      repeat (BIT_CYC) @(posedge mclk);
    end
    line <= stp;
    repeat (BIT_CYC) @(posedge mclk);
    line <= 1'b1;
  endtask
endmodule // ubam_station

// ### verif/uart_baud_and_aux_modes_tb_top.sv
// self-checking bench for the baud generator and auxiliary modes
// assumes ubam_top with a shortened wake hold-off and a station model
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module uart_baud_and_aux_modes_tb_top;
  localparam int WK = 8;
  logic        mclk = 1'b0, srst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, sin, sout, baud_tick, rx_int, core_run;
  int          bad_count = 0, num_checks = 0;
  // 250 MHz clock
  always #2 mclk = ~mclk;
  ubam_top #(.WAKE_CYCLES(WK)) ubam_top_i (.mclk, .srst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .serial_in_pin(sin), .serial_out_pin(sout), .baud_tick, .rx_int,
    .core_run);
  ubam_station #(.BIT_CYC(16)) ubam_station_i (.mclk, .line(sin));
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    rd(a);
    `CHK(r & m, e)
  endtask
  // bounded wait for the receive indication
  task automatic wait_int(input int lim);
    int k;
    k = 0;
    while (rx_int !== 1'b1 && k < lim) begin
      @(posedge mclk);
      k++;
    end
    `CHK(rx_int, 1'b1)
  endtask
  // program a rate and measure cycles between two ticks
  task automatic t_baud(input logic [4:0] c, input logic [10:0] n1,
                        input logic s, input int ex);
    int k;
    wr(ubam_pkg::OFF_PSR, 32'h0);
    wr(ubam_pkg::OFF_BAUD, {24'h0, n1[7:0]});
    wr(ubam_pkg::OFF_INTC, {31'h0, s});
    wr(ubam_pkg::OFF_PSR, {24'h0, c, n1[10:8]});
    k = 0;
    while (baud_tick !== 1'b1 && k < 9000) begin
      @(posedge mclk);
      k++;
    end
    @(posedge mclk);
    k = 1;
    while (baud_tick !== 1'b1 && k < 9000) begin
      @(posedge mclk);
      k++;
    end
    `CHK(k, ex)
  endtask
  // code zero gives no ticks
  task automatic t_stop;
    int k;
    wr(ubam_pkg::OFF_PSR, 32'h0);
    repeat (2) @(posedge mclk);
    k = 0;
    repeat (300) begin
      @(posedge mclk);
      if (baud_tick !== 1'b0) k++;
    end
    `CHK(k, 0)
  endtask
  // internal loopback in nine-bit format
  task automatic t_loop;
    wr(ubam_pkg::OFF_INTC, 32'h4);
    wr(ubam_pkg::OFF_CTRL, 32'h7);
    wr(ubam_pkg::OFF_TXBUF, 32'ha5);
    wait_int(400);
    rdc(ubam_pkg::OFF_RXBUF, 32'hff, 32'ha5);
    rdc(ubam_pkg::OFF_RXC, 32'h2, 32'h2);
    `CHK(rx_int, 1'b0)
    wr(ubam_pkg::OFF_CTRL, 32'h4);
  endtask
  // address hunt drops data until an address arrives
  task automatic t_hunt;
    wr(ubam_pkg::OFF_RXC, 32'h1);
    ubam_station_i.send(9'h03c, 1'b1);
    repeat (40) @(posedge mclk);
    `CHK(rx_int, 1'b0)
    ubam_station_i.send(9'h15a, 1'b1);
    wait_int(40);
    rdc(ubam_pkg::OFF_RXBUF, 32'hff, 32'h5a);
    rdc(ubam_pkg::OFF_RXC, 32'h3, 32'h2);
    ubam_station_i.send(9'h011, 1'b1);
    wait_int(40);
    rdc(ubam_pkg::OFF_RXBUF, 32'hff, 32'h11);
  endtask
  // framing error cleared by a bit access
  task automatic t_ferr;
    ubam_station_i.send(9'h0f0, 1'b0);
    repeat (40) @(posedge mclk);
    rdc(ubam_pkg::OFF_RXC, 32'h4, 32'h4);
    rd(ubam_pkg::OFF_BITOP);
    rdc(ubam_pkg::OFF_RXC, 32'h4, 32'h0);
    rd(ubam_pkg::OFF_RXBUF);
  endtask
  // forced break holds the output low
  task automatic t_brk;
    int k;
    wr(ubam_pkg::OFF_INTC, 32'h6);
    k = 0;
    repeat (50) begin
      @(posedge mclk);
      if (sout !== 1'b0) k++;
    end
    `CHK(k, 0)
    wr(ubam_pkg::OFF_INTC, 32'h4);
    @(posedge mclk);
    `CHK(sout, 1'b1)
  endtask
  // halt entry, reinit, then wake on a start bit
  task automatic t_halt;
    int k;
    wr(ubam_pkg::OFF_CTRL, 32'h5);
    ubam_station_i.send(9'h1c3, 1'b1);
    wait_int(40);
    wr(ubam_pkg::OFF_PWR, 32'h1d);
    // let the entry edge settle before looking at the flags
    @(posedge mclk);
    `CHK(core_run, 1'b0)
    `CHK(rx_int, 1'b0)
    rdc(ubam_pkg::OFF_CTRL, 32'h1f, 32'h0d);
    rdc(ubam_pkg::OFF_RXC, 32'h2, 32'h0);
    rdc(ubam_pkg::OFF_RXBUF, 32'hff, 32'hc3);
    `CHK(sout, 1'b1)
    fork
      ubam_station_i.send(9'h000, 1'b1);
    join_none
    k = 0;
    while (core_run !== 1'b1 && k < 200) begin
      @(posedge mclk);
      k++;
    end
    `CHK(k >= WK && k <= WK + 12, 1'b1)
    wait fork;
    rd(ubam_pkg::OFF_RXBUF);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    `CHK(sout, 1'b1)
    `CHK(core_run, 1'b1)
    rdc(ubam_pkg::OFF_PSR, 32'hff, 32'h0);
    rdc(8'h3c, 32'hffffffff, 32'h0);
    t_stop;
    t_baud(5'h1f, 11'h002, 1'b0, 768);
    t_baud(5'h02, 11'h000, 1'b1, 3);
    t_baud(5'h04, 11'h005, 1'b0, 240);
    t_baud(5'h01, 11'h100, 1'b0, 4112);
    t_baud(5'h01, 11'h000, 1'b0, 16);
    t_loop;
    t_hunt;
    t_ferr;
    t_brk;
    t_halt;
    final_report;
  end
  // watchdog, far beyond the roughly 12k cycles the tests need
  initial begin
    #400000;
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report;
  end
endmodule // uart_baud_and_aux_modes_tb_top
